// ===== dtc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far side: two count pins and two gate lines
module dtc_pin_model (
  input wire logic ref_clk,
  output logic count_pin_a,
  output logic count_pin_b,
  output logic ext_irq_line_a,
  output logic ext_irq_line_b
);
  // Pins idle high so no false edge; gates closed
  initial begin
    count_pin_a = 1'b1;
    count_pin_b = 1'b1;
    ext_irq_line_a = 1'b0;
    ext_irq_line_b = 1'b0;
  end
  // Open one gate for exactly k clocks
  task automatic gatePulse(input logic sel, input int k);
    @(posedge ref_clk);
    ext_irq_line_a <= !sel;
    ext_irq_line_b <= sel;
    repeat (k) @(posedge ref_clk);
    ext_irq_line_a <= 1'b0;
    ext_irq_line_b <= 1'b0;
  endtask : gatePulse
  // Level of line A
  task automatic setLineA(input logic v);
    @(posedge ref_clk);
    ext_irq_line_a <= v;
  endtask : setLineA
  // Falling edges on both pins, low two clocks and high three between, for the synchroniser
  task automatic pinPulse(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      count_pin_a <= 1'b0;
      count_pin_b <= 1'b0;
      repeat (2) @(posedge ref_clk);
      count_pin_a <= 1'b1;
      count_pin_b <= 1'b1;
      repeat (2) @(posedge ref_clk);
    end
  endtask : pinPulse
endmodule : dtc_pin_model
`default_nettype wire

// ===== dtc_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser with a falling-edge detector behind it
module dtc_pin_sync (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic pinIn,
  output logic pinLevel,
  output logic pinFall
);

  // First stage, read only by the second
  logic meta_ff;
  // Synchronised level
  logic sync_ff;
  // Previous synchronised sample, for the edge
  logic prev_ff;

  // Idle-high reset so no false edge after release
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
      prev_ff <= 1'b1;
    end else begin
      meta_ff <= pinIn;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign pinLevel = sync_ff;
  // One pulse per high-to-low change
  assign pinFall = prev_ff & ~sync_ff;

endmodule : dtc_pin_sync

`default_nettype wire

// ===== dtc_pkg.sv
// Shared constants for the dual timer/counter block
package dtc_pkg;

  // Bus address width and index field inside a byte address
  localparam int ADDR_W = 12;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 9;
  localparam int TOP_LSB = 10;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_MODE = 8'h89;
  localparam logic [7:0] IDX_LOW_A = 8'h8A;
  localparam logic [7:0] IDX_LOW_B = 8'h8B;
  localparam logic [7:0] IDX_HIGH_A = 8'h8C;
  localparam logic [7:0] IDX_HIGH_B = 8'h8D;
  localparam logic [7:0] IDX_CLK_CTRL = 8'h8E;
  localparam logic [7:0] IDX_RUN_CTRL = 8'h90;

  // Reset value of every byte register
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Mode register field positions
  localparam int MODE_A_LSB = 0;
  localparam int SRC_A_BIT = 2;
  localparam int GATE_A_BIT = 3;
  localparam int MODE_B_LSB = 4;
  localparam int SRC_B_BIT = 6;
  localparam int GATE_B_BIT = 7;

  // Run control register field positions
  localparam int RUN_A_BIT = 0;
  localparam int RUN_B_BIT = 1;
  localparam int TRIG_A_BIT = 2;
  localparam int OVF_A_BIT = 4;
  localparam int OVF_B_BIT = 5;
  localparam int EXTF_A_BIT = 6;

  // Prescaler width in the narrow mode
  localparam int PRESCALE_W = 5;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Counter operating modes
  typedef enum logic [1:0] {
    DTC_MODE_PRE = 2'h0,
    DTC_MODE_WIDE = 2'h1,
    DTC_MODE_RELOAD = 2'h2,
    DTC_MODE_SPLIT = 2'h3
  } dtc_mode_t;

  // Write and read channel states
  typedef enum logic {
    DTC_WR_IDLE = 1'b0,
    DTC_WR_RESP = 1'b1
  } dtc_wr_t;

  typedef enum logic {
    DTC_RD_IDLE = 1'b0,
    DTC_RD_DATA = 1'b1
  } dtc_rd_t;

endpackage : dtc_pkg

// ===== dtc_timer_props.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks on bus channels and sticky flags
module dtc_timer_props
  import dtc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic overflowFlagA,
  input wire logic overflowFlagB
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Joint handshake: refuse, then answer on the second edge
  AST_WR_ANSWER: assert property (awvalid && awready && wvalid && wready |=> !awready && !wready ##1 bvalid)
    else $error("write answer timing wrong");
  // No new write while a response waits
  AST_WR_REFUSE: assert property (bvalid |-> !awready && !wready)
    else $error("write taken during response");
  // Response holds until taken
  AST_B_STANDS: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  // Read data one cycle after the address
  AST_R_ANSWER: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read answer timing wrong");
  // Read data holds until taken
  AST_R_STANDS: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data dropped");
  // Only one byte lane carries data; two legal codes
  AST_R_BYTE: assert property (rvalid |-> rdata[31:8] == 24'h0 && (rresp == RESP_OKAY || rresp == RESP_SLVERR))
    else $error("read word malformed");
  // Flag only falls by a register write
  AST_OVFA_STICKY: assert property ($fell(overflowFlagA) |-> bvalid)
    else $error("overflow A lost");
  AST_OVFB_STICKY: assert property ($fell(overflowFlagB) |-> bvalid)
    else $error("overflow B lost");
endmodule : dtc_timer_props
bind dtc_timer_top dtc_timer_props u_props (.ref_clk, .sys_rst, .awvalid, .awready, .wvalid, .wready,
  .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .overflowFlagA, .overflowFlagB);
`default_nettype wire

// ===== dtc_timer_top.sv
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module dtc_timer_top
  import dtc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic count_pin_a,
  input wire logic count_pin_b,
  input wire logic ext_irq_line_a,
  input wire logic ext_irq_line_b,
  input wire logic irqVectorAckA,
  output logic overflowFlagA,
  output logic overflowFlagB,
  output logic extIrqFlagA
);

  // One counting step in modes 0..2; mode 3 is handled outside
  function automatic logic [16:0] stepCnt(input dtc_mode_t md, input logic inc,
                                          input logic [7:0] lo, input logic [7:0] hi);
    logic [PRESCALE_W:0] pre;
    logic [8:0] hiInc;
    logic [8:0] loInc;
    logic [16:0] wide;
    logic [16:0] res;
    pre = {1'b0, lo[PRESCALE_W-1:0]} + 6'h01;
    hiInc = {1'b0, hi} + 9'h001;
    loInc = {1'b0, lo} + 9'h001;
    wide = {1'b0, hi, lo} + 17'h00001;
    res = {1'b0, hi, lo};
    if (inc) begin
      unique case (md)
        DTC_MODE_PRE: begin
          res = {pre[PRESCALE_W] & hiInc[8], pre[PRESCALE_W] ? hiInc[7:0] : hi,
                 lo[7:PRESCALE_W], pre[PRESCALE_W-1:0]};
        end
        DTC_MODE_WIDE: begin
          res = wide;
        end
        DTC_MODE_RELOAD: begin
          res = {loInc[8], hi, loInc[8] ? hi : loInc[7:0]};
        end
        // Split mode counted by the caller
        DTC_MODE_SPLIT: begin
          res = {1'b0, hi, lo};
        end
      endcase
    end
    return res;
  endfunction : stepCnt

  // Byte registers
  logic [7:0] modeReg_ff, lowA_ff, highA_ff, lowB_ff, highB_ff;
  // Clock control is storage only here
  logic [7:0] clkCtrl_ff;
  // Run bits and trigger type
  logic runA_ff, runB_ff, trigA_ff;
  // Sticky flags
  logic ovfA_ff, ovfB_ff, extfA_ff;

  // Bus channel state
  dtc_wr_t wrSt_ff;
  dtc_rd_t rdSt_ff;
  logic awHave_ff;
  logic wHave_ff;
  logic [ADDR_W-1:0] awAddr_ff;
  logic [7:0] wByte_ff;
  logic wLane_ff;
  logic [1:0] bresp_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;

  // Synchronised pins; levels of count pins and edges of line B go unused
  logic cntFallA, cntFallB, irqLvlA, irqLvlB, irqFallA;

  // count pins sampled and edge detected
  dtc_pin_sync u_sync_cnt_a (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .pinIn(count_pin_a), .pinLevel(), .pinFall(cntFallA));

  dtc_pin_sync u_sync_cnt_b (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .pinIn(count_pin_b), .pinLevel(), .pinFall(cntFallB));

  // Gate lines through the same path, giving matching latency
  dtc_pin_sync u_sync_irq_a (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .pinIn(ext_irq_line_a), .pinLevel(irqLvlA), .pinFall(irqFallA));

  dtc_pin_sync u_sync_irq_b (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .pinIn(ext_irq_line_b), .pinLevel(irqLvlB), .pinFall());

  // Mode fields
  dtc_mode_t modeA;
  dtc_mode_t modeB;
  assign modeA = dtc_mode_t'(modeReg_ff[MODE_A_LSB+1:MODE_A_LSB]);
  assign modeB = dtc_mode_t'(modeReg_ff[MODE_B_LSB+1:MODE_B_LSB]);

  // Enables after gating
  wire enA;
  wire enB;
  // B gating by line and run
  assign enB = runB_ff & (~modeReg_ff[GATE_B_BIT] | irqLvlB);
  // A gating by its own line
  assign enA = runA_ff & (~modeReg_ff[GATE_A_BIT] | irqLvlA);

  // Count requests per source select
  wire incA;
  wire incB;
  assign incA = enA & (modeReg_ff[SRC_A_BIT] ? cntFallA : 1'b1);
  assign incB = enB & (modeReg_ff[SRC_B_BIT] ? cntFallB : 1'b1);

  // Split mode of A
  wire splitA;
  wire stopB;
  assign splitA = (modeA == DTC_MODE_SPLIT);
  // B frozen in its mode 3
  assign stopB = (modeB == DTC_MODE_SPLIT);

  wire [16:0] stepA;
  wire [16:0] stepB;
  assign stepA = stepCnt(modeA, incA, lowA_ff, highA_ff);
  assign stepB = stepCnt(modeB, incB & ~stopB, lowB_ff, highB_ff);

  // Split-mode byte increments
  wire [8:0] lowAInc;
  wire [8:0] highAInc;
  assign lowAInc = {1'b0, lowA_ff} + 9'h001;
  assign highAInc = {1'b0, highA_ff} + 9'h001;

  // Overflow events
  wire ovfAEvt;
  wire ovfBEvt;
  assign ovfAEvt = splitA ? (incA & lowAInc[8]) : stepA[16];
  // high byte of A reports through B's flag
  assign ovfBEvt = splitA ? (runB_ff & highAInc[8]) : stepB[16];

  // Write decode
  wire doWrite, wHit;
  wire [7:0] wIdx;
  wire wrMode, wrLowA, wrHighA, wrLowB, wrHighB, wrClk, wrRun;
  assign doWrite = (wrSt_ff == DTC_WR_IDLE) & awHave_ff & wHave_ff;
  assign wIdx = awAddr_ff[IDX_MSB:IDX_LSB];
  assign wHit = (awAddr_ff[ADDR_W-1:TOP_LSB] == '0) &
                (wIdx inside {IDX_MODE, IDX_LOW_A, IDX_LOW_B, IDX_HIGH_A,
                              IDX_HIGH_B, IDX_CLK_CTRL, IDX_RUN_CTRL});
  // Only lane 0 carries register data
  assign wrMode = doWrite & wLane_ff & (wIdx == IDX_MODE) & wHit;
  assign wrLowA = doWrite & wLane_ff & (wIdx == IDX_LOW_A) & wHit;
  assign wrHighA = doWrite & wLane_ff & (wIdx == IDX_HIGH_A) & wHit;
  assign wrLowB = doWrite & wLane_ff & (wIdx == IDX_LOW_B) & wHit;
  assign wrHighB = doWrite & wLane_ff & (wIdx == IDX_HIGH_B) & wHit;
  assign wrClk = doWrite & wLane_ff & (wIdx == IDX_CLK_CTRL) & wHit;
  assign wrRun = doWrite & wLane_ff & (wIdx == IDX_RUN_CTRL) & wHit;

  // Next count bytes; a software write beats counting
  wire [7:0] nxt_lowA, nxt_highA, nxt_lowB, nxt_highB;
  // split A: low under A, high under B run
  assign nxt_lowA = wrLowA ? wByte_ff : splitA ? (incA ? lowAInc[7:0] : lowA_ff) : stepA[7:0];
  assign nxt_highA = wrHighA ? wByte_ff : splitA ? (runB_ff ? highAInc[7:0] : highA_ff) : stepA[15:8];
  assign nxt_lowB = wrLowB ? wByte_ff : stepB[7:0];
  assign nxt_highB = wrHighB ? wByte_ff : stepB[15:8];

  // Flag clear by writing zero to the bit
  wire clrOvfA, clrOvfB, clrExtA;
  assign clrOvfA = wrRun & ~wByte_ff[OVF_A_BIT];
  assign clrOvfB = wrRun & ~wByte_ff[OVF_B_BIT];
  assign clrExtA = wrRun & ~wByte_ff[EXTF_A_BIT];

  // Sticky flags, set wins over clear; ext flag A sticky in edge mode only
  wire nxt_ovfA, nxt_ovfB, nxt_extfA;
  assign nxt_ovfA = ovfAEvt | (ovfA_ff & ~clrOvfA);
  assign nxt_ovfB = ovfBEvt | (ovfB_ff & ~clrOvfB);
  assign nxt_extfA = trigA_ff ? (irqFallA | (extfA_ff & ~(irqVectorAckA | clrExtA))) : ~irqLvlA;

  // Counter and control registers
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      modeReg_ff <= RST_BYTE;
      lowA_ff <= RST_BYTE;
      highA_ff <= RST_BYTE;
      lowB_ff <= RST_BYTE;
      highB_ff <= RST_BYTE;
      clkCtrl_ff <= RST_BYTE;
      runA_ff <= 1'b0;
      runB_ff <= 1'b0;
      trigA_ff <= 1'b0;
      ovfA_ff <= 1'b0;
      ovfB_ff <= 1'b0;
      extfA_ff <= 1'b0;
    end else begin
      lowA_ff <= nxt_lowA;
      highA_ff <= nxt_highA;
      lowB_ff <= nxt_lowB;
      highB_ff <= nxt_highB;
      ovfA_ff <= nxt_ovfA;
      ovfB_ff <= nxt_ovfB;
      extfA_ff <= nxt_extfA;
      if (wrMode) begin
        modeReg_ff <= wByte_ff;
      end
      if (wrClk) begin
        clkCtrl_ff <= wByte_ff;
      end
      if (wrRun) begin
        runA_ff <= wByte_ff[RUN_A_BIT];
        runB_ff <= wByte_ff[RUN_B_BIT];
        trigA_ff <= wByte_ff[TRIG_A_BIT];
      end
    end
  end

  // Write channel: address and data accepted in either order
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wrSt_ff <= DTC_WR_IDLE;
      awHave_ff <= 1'b0;
      wHave_ff <= 1'b0;
      awAddr_ff <= '0;
      wByte_ff <= RST_BYTE;
      wLane_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else begin
      unique case (wrSt_ff)
        DTC_WR_IDLE: begin
          if (awvalid & awready) begin
            awHave_ff <= 1'b1;
            awAddr_ff <= awaddr;
          end
          if (wvalid & wready) begin
            wHave_ff <= 1'b1;
            wByte_ff <= wdata[7:0];
            wLane_ff <= wstrb[0];
          end
          // Both halves held: commit and answer
          if (doWrite) begin
            wrSt_ff <= DTC_WR_RESP;
            bresp_ff <= wHit ? RESP_OKAY : RESP_SLVERR;
          end
        end
        DTC_WR_RESP: begin
          if (bready) begin
            wrSt_ff <= DTC_WR_IDLE;
            awHave_ff <= 1'b0;
            wHave_ff <= 1'b0;
          end
        end
      endcase
    end
  end

  assign awready = (wrSt_ff == DTC_WR_IDLE) & ~awHave_ff;
  assign wready = (wrSt_ff == DTC_WR_IDLE) & ~wHave_ff;
  assign bvalid = (wrSt_ff == DTC_WR_RESP);
  assign bresp = bresp_ff;

  // Read decode, continuous
  wire [7:0] rIdx;
  wire rTopOk;
  wire [7:0] runView;
  logic [7:0] rByte;
  logic rHit;
  assign rIdx = araddr[IDX_MSB:IDX_LSB];
  assign rTopOk = (araddr[ADDR_W-1:TOP_LSB] == '0);
  // Run register shows live flags
  assign runView = {1'b0, extfA_ff, ovfB_ff, ovfA_ff, 1'b0, trigA_ff, runB_ff, runA_ff};

  // Read mux; unmapped reads zero with an error
  always_comb begin
    rByte = RST_BYTE;
    rHit = rTopOk;
    unique case (rIdx)
      IDX_MODE: rByte = modeReg_ff;
      IDX_LOW_A: rByte = lowA_ff;
      IDX_LOW_B: rByte = lowB_ff;
      IDX_HIGH_A: rByte = highA_ff;
      IDX_HIGH_B: rByte = highB_ff;
      IDX_CLK_CTRL: rByte = clkCtrl_ff;
      IDX_RUN_CTRL: rByte = runView;
      default: rHit = 1'b0;
    endcase
    if (!rTopOk) begin
      rByte = RST_BYTE;
    end
  end

  // Read channel: one cycle to data, held until taken
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdSt_ff <= DTC_RD_IDLE;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
    end else begin
      unique case (rdSt_ff)
        DTC_RD_IDLE: begin
          if (arvalid) begin
            rdSt_ff <= DTC_RD_DATA;
            rdata_ff <= {24'h000000, rByte};
            rresp_ff <= rHit ? RESP_OKAY : RESP_SLVERR;
          end
        end
        DTC_RD_DATA: begin
          if (rready) begin
            rdSt_ff <= DTC_RD_IDLE;
          end
        end
      endcase
    end
  end

  assign arready = (rdSt_ff == DTC_RD_IDLE);
  assign rvalid = (rdSt_ff == DTC_RD_DATA);
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;

  // Flags out to the interrupt controller
  assign overflowFlagA = ovfA_ff;
  assign overflowFlagB = ovfB_ff;
  assign extIrqFlagA = extfA_ff;

endmodule : dtc_timer_top

`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none
// Register-level tests of the dual timer/counter
module testbench;
  import dtc_pkg::*;
  logic ref_clk, sys_rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irqVectorAckA, overflowFlagA, overflowFlagB, extIrqFlagA;
  logic count_pin_a, count_pin_b, ext_irq_line_a, ext_irq_line_b;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rdv;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsv;
  int badCount, checkCount;
  logic [7:0] idxList [6] = '{IDX_MODE, IDX_LOW_A, IDX_LOW_B, IDX_HIGH_A, IDX_HIGH_B, IDX_CLK_CTRL};

  dtc_timer_top dut (.ref_clk, .sys_rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .count_pin_a,
    .count_pin_b, .ext_irq_line_a, .ext_irq_line_b, .irqVectorAckA, .overflowFlagA, .overflowFlagB, .extIrqFlagA);
  dtc_pin_model pm (.ref_clk, .count_pin_a, .count_pin_b, .ext_irq_line_a, .ext_irq_line_b);

  // Free-running core clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // Compare and count
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      badCount++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Verdict and end of run
  task automatic endSim();
    $display("checks %0d mismatches %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : endSim

  // One transfer; each channel held until its own handshake edge
  task automatic busOp(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] v);
    logic done, awGo, wGo, arGo, fin;
    done = 1'b0;
    @(posedge ref_clk);
    if (wr) begin
      awaddr <= a;
      wdata <= {24'h0, v};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end else begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    while (!done) begin
      // Settled view of what the next edge will sample
      #1;
      awGo = awvalid && awready;
      wGo = wvalid && wready;
      arGo = arvalid && arready;
      fin = wr ? (bvalid === 1'b1) : (rvalid === 1'b1);
      rdv = rdata;
      rsv = wr ? bresp : rresp;
      @(posedge ref_clk);
      if (awGo) awvalid <= 1'b0;
      if (wGo) wvalid <= 1'b0;
      if (arGo) arvalid <= 1'b0;
      if (fin) begin
        bready <= 1'b0;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
    #1;
  endtask : busOp

  // Byte address from register index
  function automatic logic [ADDR_W-1:0] adr(input logic [7:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction : adr

  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    busOp(1'b1, adr(idx), v);
    check("write resp", {30'h0, rsv}, {30'h0, RESP_OKAY});
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    busOp(1'b0, adr(idx), 8'h00);
    check($sformatf("reg %h", idx), {rsv, rdv[29:0]}, {RESP_OKAY, 22'h0, exp});
  endtask : rd

  // Let counts settle past the synchronisers
  task automatic waitCyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : waitCyc

  // Hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    badCount++;
    endSim();
  end

  initial begin
    sys_rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, irqVectorAckA} = 6'h00;
    awaddr = '0;
    araddr = '0;
    wdata = 32'h0;
    wstrb = 4'hF;
    badCount = 0;
    checkCount = 0;
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    waitCyc(4);
    // Reset values; level flag mirrors the low line
    foreach (idxList[i]) rd(idxList[i], RST_BYTE);
    rd(IDX_RUN_CTRL, 8'h40);
    check("ovf flags", {30'h0, overflowFlagA, overflowFlagB}, 32'h0);
    // Unmapped places refuse and store nothing
    busOp(1'b1, adr(8'h88), 8'hFF);
    check("unmapped write", {30'h0, rsv}, {30'h0, RESP_SLVERR});
    busOp(1'b1, 12'h624, 8'hFF);
    check("high write", {30'h0, rsv}, {30'h0, RESP_SLVERR});
    busOp(1'b0, 12'h624, 8'h00);
    check("unmapped read", {rsv, rdv[29:0]}, {RESP_SLVERR, 30'h0});
    rd(IDX_MODE, RST_BYTE);
    wr(IDX_CLK_CTRL, 8'hA5);
    rd(IDX_CLK_CTRL, 8'hA5);
    // Wide gated timer A: count equals gate width
    wr(IDX_MODE, 8'h09);
    wr(IDX_LOW_A, 8'hFE);
    wr(IDX_HIGH_A, 8'h12);
    wr(IDX_RUN_CTRL, 8'h01);
    pm.gatePulse(1'b0, 5);
    waitCyc(4);
    rd(IDX_LOW_A, 8'h03);
    rd(IDX_HIGH_A, 8'h13);
    // Prescale mode: carry out of five bits, top bits kept
    wr(IDX_MODE, 8'h08);
    wr(IDX_LOW_A, 8'hFE);
    wr(IDX_HIGH_A, 8'hFF);
    pm.gatePulse(1'b0, 3);
    waitCyc(4);
    rd(IDX_LOW_A, 8'hE1);
    rd(IDX_HIGH_A, 8'h00);
    check("ovf A", {31'h0, overflowFlagA}, 32'h1);
    // Reload mode on B, gated by line B
    wr(IDX_MODE, 8'hA0);
    wr(IDX_LOW_B, 8'hFE);
    wr(IDX_HIGH_B, 8'h40);
    wr(IDX_RUN_CTRL, 8'h02);
    check("ovf A cleared", {31'h0, overflowFlagA}, 32'h0);
    pm.gatePulse(1'b1, 4);
    waitCyc(4);
    rd(IDX_LOW_B, 8'h42);
    rd(IDX_HIGH_B, 8'h40);
    check("ovf B", {31'h0, overflowFlagB}, 32'h1);
    // Pin sources, gates off: one count per falling edge
    wr(IDX_MODE, 8'h55);
    wr(IDX_LOW_A, 8'h00);
    wr(IDX_LOW_B, 8'h00);
    wr(IDX_RUN_CTRL, 8'h03);
    pm.pinPulse(3);
    waitCyc(4);
    rd(IDX_LOW_A, 8'h03);
    rd(IDX_LOW_B, 8'h03);
    // Reload mode on A, gated by line A: wrap reloads from high byte
    wr(IDX_MODE, 8'h0A);
    wr(IDX_LOW_A, 8'hFF);
    wr(IDX_HIGH_A, 8'h80);
    wr(IDX_RUN_CTRL, 8'h01);
    pm.gatePulse(1'b0, 3);
    waitCyc(4);
    rd(IDX_LOW_A, 8'h82);
    check("ovf A reload", {31'h0, overflowFlagA}, 32'h1);
    // Split A, frozen B; high A runs on B's run bit
    wr(IDX_LOW_B, 8'h55);
    wr(IDX_MODE, 8'h3B);
    wr(IDX_LOW_A, 8'h10);
    wr(IDX_RUN_CTRL, 8'h03);
    wr(IDX_HIGH_A, 8'hFF);
    pm.gatePulse(1'b0, 2);
    waitCyc(4);
    rd(IDX_LOW_A, 8'h12);
    check("ovf B split", {31'h0, overflowFlagB}, 32'h1);
    rd(IDX_LOW_B, 8'h55);
    // Edge trigger: set on fall, cleared on vector
    wr(IDX_RUN_CTRL, 8'h04);
    // Level flag survives the switch; clear it once edge mode holds
    wr(IDX_RUN_CTRL, 8'h04);
    check("edge flag idle", {31'h0, extIrqFlagA}, 32'h0);
    pm.setLineA(1'b1);
    waitCyc(4);
    pm.setLineA(1'b0);
    waitCyc(4);
    check("edge flag set", {31'h0, extIrqFlagA}, 32'h1);
    @(posedge ref_clk);
    irqVectorAckA <= 1'b1;
    @(posedge ref_clk);
    irqVectorAckA <= 1'b0;
    waitCyc(2);
    check("edge flag ack", {31'h0, extIrqFlagA}, 32'h0);
    // Level trigger: flag is the inverted line
    wr(IDX_RUN_CTRL, 8'h00);
    waitCyc(4);
    check("level flag low", {31'h0, extIrqFlagA}, 32'h1);
    pm.setLineA(1'b1);
    waitCyc(4);
    check("level flag high", {31'h0, extIrqFlagA}, 32'h0);
    endSim();
  end
endmodule : testbench
`default_nettype wire
